//--- core/dps_flag_pkg.sv
// Package of constants and types for the flag logic, plus the alarm qualifying delay
`timescale 1ns/1ns
`default_nettype none

package dps_pkg;
  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_MHZ         = 100;
  localparam int unsigned KELVIN_DELAY_US = 50;
  localparam int unsigned GUARD_DELAY_US  = 200;
  localparam int unsigned KELVIN_DELAY_CYC = KELVIN_DELAY_US * CLK_MHZ;
  localparam int unsigned GUARD_DELAY_CYC  = GUARD_DELAY_US * CLK_MHZ;
  localparam int unsigned DELAY_W          = 16;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [3:0] ADDR_DPS1     = 4'h2;
  localparam logic [3:0] ADDR_DPS2     = 4'h3;
  localparam logic [3:0] ADDR_ALARM    = 4'h6;
  localparam logic [3:0] ADDR_DIAG     = 4'h7;
  localparam logic [3:0] ADDR_CLAMP_LO = 4'h8;
  localparam logic [3:0] ADDR_CLAMP_HI = 4'h9;
  localparam logic [3:0] ADDR_GND_THR  = 4'ha;
  localparam logic [3:0] ADDR_CMP_LO   = 4'hb;
  localparam logic [3:0] ADDR_CMP_HI   = 4'hc;
  localparam logic [3:0] ADDR_STATUS   = 4'hd;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int unsigned SWINH_BIT      = 0;
  localparam int unsigned WINDOW_BIT     = 0;
  localparam int unsigned GPO_BIT        = 1;
  localparam int unsigned GUARD_TRI_BIT  = 2;
  localparam int unsigned SYS_GND_BIT    = 3;
  localparam int unsigned LOAD_SEL_LSB   = 4;
  localparam int unsigned CLAMP_LAT_BIT  = 6;
  localparam int unsigned GUARD_LAT_BIT  = 7;
  localparam int unsigned GND_DIS_BIT    = 10;
  localparam int unsigned GND_LAT_BIT    = 11;
  localparam int unsigned SENSE_LAT_BIT  = 13;
  localparam int unsigned ST_SENSE       = 0;
  localparam int unsigned ST_GND         = 1;
  localparam int unsigned ST_GUARD       = 2;
  localparam int unsigned ST_CLAMP       = 3;
  localparam int unsigned ST_KEL_PIN     = 4;
  localparam int unsigned ST_CLAMP_PIN   = 5;

  // ------------------------------------------------------------------
  // Codes and reset values
  // ------------------------------------------------------------------
  localparam logic [15:0] CLAMP_LO_MAX   = 16'h7fff;
  localparam logic [15:0] CLAMP_HI_MIN   = 16'h8000;
  localparam logic [15:0] GND_THR_RESET  = 16'h3333;
  localparam logic [15:0] CLAMP_LO_RESET = 16'h0000;
  localparam logic [15:0] CLAMP_HI_RESET = 16'hffff;
  localparam logic [15:0] CMP_RESET      = 16'h0000;
  localparam logic [15:0] REG_RESET      = 16'h0000;

  typedef enum logic [1:0] {
    LOAD_NONE  = 2'h0,
    LOAD_CLAMP = 2'h1,
    LOAD_INH   = 2'h2
  } dps_load_e;

  typedef struct packed {
    logic senseOpen;
    logic groundFault;
    logic guardShort;
    logic clampHit;
    logic measAboveHigh;
    logic measAboveLow;
  } dps_sense_s;

  typedef struct packed {
    logic [15:0] lowCurrentLimit;
    logic [15:0] highCurrentLimit;
    logic [15:0] groundSenseThresholdDac;
    logic [15:0] lowCompareLevel;
    logic [15:0] highCompareLevel;
  } dps_levels_s;
endpackage : dps_pkg

module dps_alarm_delay #(
  parameter logic [dps_pkg::DELAY_W-1:0] LIMIT = 16'h0001
) (
  input  wire logic mclk,   // System clock
  input  wire logic reset,  // Async reset, high
  input  wire logic cond,   // Raw alarm condition
  output logic      ripe    // Condition held LIMIT cycles
);
  logic [dps_pkg::DELAY_W-1:0] count;
  logic [dps_pkg::DELAY_W-1:0] next_count;

  // Any gap in the condition restarts the wait, so glitches never flag
  always_comb begin
    if (!cond) begin
      next_count = '0;
    end else if (count == LIMIT) begin
      next_count = count;
    end else begin
      next_count = count + 16'h0001;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign ripe = (count == LIMIT);
endmodule : dps_alarm_delay

`default_nettype wire

//--- core/dps_flag_logic.sv
// Alarm, comparator and clamp flag logic of the power supply channel
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module dps_flag_logic #(
  parameter logic [15:0] KELVIN_DELAY = 16'(dps_pkg::KELVIN_DELAY_CYC),
  parameter logic [15:0] GUARD_DELAY  = 16'(dps_pkg::GUARD_DELAY_CYC)
) (
  input  wire logic                 mclk,               // 100 MHz clock
  input  wire logic                 reset,              // Async reset, high
  input  wire logic [3:0]           regAddr,            // Register address
  input  wire logic [15:0]          regWrData,          // Write data
  input  wire logic                 regWrite,           // Write strobe
  input  wire logic                 regRead,            // Read strobe
  output logic [15:0]               regRdData,          // Read data, next cycle
  input  wire dps_pkg::dps_sense_s  sense,              // Analog detector results
  input  wire logic                 clampEnablePin,     // Clamp enable or load
  input  wire logic                 hardwareInhibitN,   // Inhibit or load, low
  input  wire logic                 kelvinAlarmNIn,     // Kelvin flag wire level
  output logic                      kelvinAlarmNOut,    // Kelvin flag drive value
  output logic                      kelvinAlarmNOeN,    // Kelvin flag drive, low
  input  wire logic                 clampAlarmNIn,      // Clamp flag wire level
  output logic                      clampAlarmNOut,     // Clamp flag drive value
  output logic                      clampAlarmNOeN,     // Clamp flag drive, low
  output logic                      generalOutputPin,   // General output value
  output logic                      generalOutputOeN,   // General output drive, low
  output logic [3:0]                diodeSelect,        // Thermal diode select
  output logic                      highCompareOut,     // High or window compare
  output logic                      lowCompareOut,      // Low compare
  output dps_pkg::dps_levels_s      levels,             // Active DAC levels
  output logic                      groundPullupEnable, // Ground pin pull-up on
  output logic                      forceHighZ,         // Force amp high-Z
  output logic                      clampActive,        // Clamping enabled
  output logic                      guardTristate,      // Guard amp tristated
  output logic                      systemGroundSwitch  // System ground closed
);
  // ------------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------------
  logic [15:0]          dps1, dps2, alarmCfg, diag, status;
  logic [15:0]          next_dps1, next_dps2, next_alarmCfg, next_diag, next_status;
  dps_pkg::dps_levels_s staged, next_staged;
  logic [15:0]          next_regRdData;
  logic [5:0]           setBits;
  logic [15:0]          clearBits;

  logic windowMode, gpoBit, guardTriBit, sysGndBit, clampLatch;
  logic guardLatch, gndDisable, gndLatch, senseLatch, swInhibit;
  dps_pkg::dps_load_e loadSel;

  assign swInhibit   = dps1[dps_pkg::SWINH_BIT];
  assign windowMode  = dps2[dps_pkg::WINDOW_BIT];
  assign gpoBit      = dps2[dps_pkg::GPO_BIT];
  assign guardTriBit = dps2[dps_pkg::GUARD_TRI_BIT];
  assign sysGndBit   = dps2[dps_pkg::SYS_GND_BIT];
  assign clampLatch  = dps2[dps_pkg::CLAMP_LAT_BIT];
  assign guardLatch  = alarmCfg[dps_pkg::GUARD_LAT_BIT];
  assign gndDisable  = alarmCfg[dps_pkg::GND_DIS_BIT];
  assign gndLatch    = alarmCfg[dps_pkg::GND_LAT_BIT];
  assign senseLatch  = alarmCfg[dps_pkg::SENSE_LAT_BIT];

  // Encoding allows only one pin as load strobe; code 3 acts as none
  always_comb begin
    unique case (dps2[dps_pkg::LOAD_SEL_LSB +: 2])
      2'h1:    loadSel = dps_pkg::LOAD_CLAMP;
      2'h2:    loadSel = dps_pkg::LOAD_INH;
      default: loadSel = dps_pkg::LOAD_NONE;
    endcase
  end

  always_comb begin
    next_dps1     = dps1;
    next_dps2     = dps2;
    next_alarmCfg = alarmCfg;
    next_diag     = diag;
    next_staged   = staged;
    clearBits     = 16'h0000;
    if (regWrite) begin
      unique case (regAddr)
        dps_pkg::ADDR_DPS1:  next_dps1 = regWrData;
        dps_pkg::ADDR_DPS2:  next_dps2 = regWrData;
        dps_pkg::ADDR_ALARM: next_alarmCfg = regWrData;
        dps_pkg::ADDR_DIAG:  next_diag = regWrData;
        dps_pkg::ADDR_CLAMP_LO: begin
          next_staged.lowCurrentLimit = (regWrData > dps_pkg::CLAMP_LO_MAX) ?
                                        dps_pkg::CLAMP_LO_MAX : regWrData;
        end
        dps_pkg::ADDR_CLAMP_HI: begin
          next_staged.highCurrentLimit = (regWrData < dps_pkg::CLAMP_HI_MIN) ?
                                         dps_pkg::CLAMP_HI_MIN : regWrData;
        end
        dps_pkg::ADDR_GND_THR: next_staged.groundSenseThresholdDac = regWrData;
        dps_pkg::ADDR_CMP_LO:  next_staged.lowCompareLevel = regWrData;
        dps_pkg::ADDR_CMP_HI:  next_staged.highCompareLevel = regWrData;
        dps_pkg::ADDR_STATUS:  clearBits = regWrData;
        default: ;
      endcase
    end
    // Set wins over a clear in the same cycle so no event is lost
    next_status = 16'h0000;
    next_status[5:0] = (status[5:0] & ~clearBits[5:0]) | setBits;
  end

  always_comb begin
    next_regRdData = 16'h0000;
    if (regRead) begin
      unique case (regAddr)
        dps_pkg::ADDR_DPS1:     next_regRdData = dps1;
        dps_pkg::ADDR_DPS2:     next_regRdData = dps2;
        dps_pkg::ADDR_ALARM:    next_regRdData = alarmCfg;
        dps_pkg::ADDR_DIAG:     next_regRdData = diag;
        dps_pkg::ADDR_CLAMP_LO: next_regRdData = staged.lowCurrentLimit;
        dps_pkg::ADDR_CLAMP_HI: next_regRdData = staged.highCurrentLimit;
        dps_pkg::ADDR_GND_THR:  next_regRdData = staged.groundSenseThresholdDac;
        dps_pkg::ADDR_CMP_LO:   next_regRdData = staged.lowCompareLevel;
        dps_pkg::ADDR_CMP_HI:   next_regRdData = staged.highCompareLevel;
        dps_pkg::ADDR_STATUS: begin
          next_regRdData = status;
          next_regRdData[dps_pkg::ST_KEL_PIN]   = ~kelvinAlarmNIn;
          next_regRdData[dps_pkg::ST_CLAMP_PIN] = ~clampAlarmNIn;
        end
        default: next_regRdData = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      dps1      <= dps_pkg::REG_RESET;
      dps2      <= dps_pkg::REG_RESET;
      alarmCfg  <= dps_pkg::REG_RESET;
      diag      <= dps_pkg::REG_RESET;
      status    <= dps_pkg::REG_RESET;
      regRdData <= dps_pkg::REG_RESET;
      staged    <= {dps_pkg::CLAMP_LO_RESET, dps_pkg::CLAMP_HI_RESET,
                    dps_pkg::GND_THR_RESET, dps_pkg::CMP_RESET, dps_pkg::CMP_RESET};
    end else begin
      dps1      <= next_dps1;
      dps2      <= next_dps2;
      alarmCfg  <= next_alarmCfg;
      diag      <= next_diag;
      status    <= next_status;
      regRdData <= next_regRdData;
      staged    <= next_staged;
    end
  end

  // ------------------------------------------------------------------
  // Load strobe and active levels
  // ------------------------------------------------------------------
  logic loadPin, loadPinPrev, next_loadPinPrev, loadFall;
  dps_pkg::dps_levels_s next_levels;

  assign loadPin  = (loadSel == dps_pkg::LOAD_CLAMP) ? clampEnablePin : hardwareInhibitN;
  assign loadFall = loadPinPrev & ~loadPin;

  // Without a strobe levels follow writes one cycle late; with one they wait
  always_comb begin
    next_loadPinPrev = loadPin;
    next_levels      = levels;
    if (loadSel == dps_pkg::LOAD_NONE || loadFall) begin
      next_levels = staged;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      loadPinPrev <= 1'b1;
      levels      <= {dps_pkg::CLAMP_LO_RESET, dps_pkg::CLAMP_HI_RESET,
                      dps_pkg::GND_THR_RESET, dps_pkg::CMP_RESET, dps_pkg::CMP_RESET};
    end else begin
      loadPinPrev <= next_loadPinPrev;
      levels      <= next_levels;
    end
  end

  // ------------------------------------------------------------------
  // Alarm qualification
  // ------------------------------------------------------------------
  logic senseRipe, gndRipe, guardRipe;

  dps_alarm_delay #(.LIMIT(KELVIN_DELAY)) uSenseDelay (
    .mclk  (mclk),
    .reset (reset),
    .cond  (sense.senseOpen),
    .ripe  (senseRipe)
  );

  dps_alarm_delay #(.LIMIT(KELVIN_DELAY)) uGndDelay (
    .mclk  (mclk),
    .reset (reset),
    .cond  (sense.groundFault & ~gndDisable),
    .ripe  (gndRipe)
  );

  dps_alarm_delay #(.LIMIT(GUARD_DELAY)) uGuardDelay (
    .mclk  (mclk),
    .reset (reset),
    .cond  (sense.guardShort),
    .ripe  (guardRipe)
  );

  always_comb begin
    setBits = 6'h00;
    setBits[dps_pkg::ST_SENSE] = senseRipe;
    setBits[dps_pkg::ST_GND]   = gndRipe & ~gndDisable;
    setBits[dps_pkg::ST_GUARD] = guardRipe;
    setBits[dps_pkg::ST_CLAMP] = sense.clampHit;
  end

  // ------------------------------------------------------------------
  // Pin outputs
  // ------------------------------------------------------------------
  logic kelvinOn, clampOn;
  logic next_kelvinAlarmNOeN, next_clampAlarmNOeN, next_generalOutputPin;
  logic next_generalOutputOeN, next_highCompareOut, next_lowCompareOut;
  logic next_groundPullupEnable, next_forceHighZ, next_clampActive;
  logic next_guardTristate, next_systemGroundSwitch;
  logic [3:0] next_diodeSelect;

  always_comb begin
    kelvinOn = (senseLatch ? status[dps_pkg::ST_SENSE] : senseRipe)
             | ((gndLatch ? status[dps_pkg::ST_GND] : gndRipe) & ~gndDisable)
             | (guardLatch ? status[dps_pkg::ST_GUARD] : guardRipe);
    clampOn  = clampLatch ? status[dps_pkg::ST_CLAMP] : sense.clampHit;
    next_kelvinAlarmNOeN    = ~kelvinOn;
    next_clampAlarmNOeN     = ~clampOn;
    next_diodeSelect        = diag[3:0];
    // A selected diode owns the pin, so the digital driver lets go
    next_generalOutputOeN   = (diag[3:0] != 4'h0);
    next_generalOutputPin   = gpoBit;
    if (windowMode) begin
      next_highCompareOut = sense.measAboveLow & ~sense.measAboveHigh;
    end else begin
      next_highCompareOut = ~sense.measAboveHigh;
    end
    next_lowCompareOut      = sense.measAboveLow;
    next_groundPullupEnable = ~gndDisable;
    next_forceHighZ = swInhibit
                    | (~hardwareInhibitN & (loadSel != dps_pkg::LOAD_INH));
    next_clampActive = (loadSel == dps_pkg::LOAD_CLAMP) ? 1'b1 : clampEnablePin;
    next_guardTristate      = guardTriBit;
    next_systemGroundSwitch = sysGndBit & guardTriBit;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      kelvinAlarmNOeN    <= 1'b1;
      clampAlarmNOeN     <= 1'b1;
      generalOutputPin   <= 1'b0;
      generalOutputOeN   <= 1'b0;
      diodeSelect        <= 4'h0;
      highCompareOut     <= 1'b0;
      lowCompareOut      <= 1'b0;
      groundPullupEnable <= 1'b1;
      forceHighZ         <= 1'b1;
      clampActive        <= 1'b0;
      guardTristate      <= 1'b0;
      systemGroundSwitch <= 1'b0;
    end else begin
      kelvinAlarmNOeN    <= next_kelvinAlarmNOeN;
      clampAlarmNOeN     <= next_clampAlarmNOeN;
      generalOutputPin   <= next_generalOutputPin;
      generalOutputOeN   <= next_generalOutputOeN;
      diodeSelect        <= next_diodeSelect;
      highCompareOut     <= next_highCompareOut;
      lowCompareOut      <= next_lowCompareOut;
      groundPullupEnable <= next_groundPullupEnable;
      forceHighZ         <= next_forceHighZ;
      clampActive        <= next_clampActive;
      guardTristate      <= next_guardTristate;
      systemGroundSwitch <= next_systemGroundSwitch;
    end
  end

  // Open-drain flags only ever pull low
  assign kelvinAlarmNOut = 1'b0;
  assign clampAlarmNOut  = 1'b0;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_sw_inhibit_hiz: assert property (swInhibit |=> forceHighZ)
    else $error("software inhibit did not tristate force amp");
  a_clamp_low_sat: assert property (
    regWrite && regAddr == dps_pkg::ADDR_CLAMP_LO && regWrData > 16'h7fff
    |=> staged.lowCurrentLimit == 16'h7fff)
    else $error("low clamp code not saturated");
  a_clamp_high_floor: assert property (
    regWrite && regAddr == dps_pkg::ADDR_CLAMP_HI && regWrData < 16'h8000
    |=> staged.highCurrentLimit == 16'h8000)
    else $error("high clamp code below range");
  a_gnd_disable: assert property (gndDisable && $past(gndDisable)
    |-> !$rose(status[dps_pkg::ST_GND]) && !groundPullupEnable)
    else $error("ground alarm active while disabled");
  a_sense_delay: assert property (!sense.senseOpen |=> !senseRipe)
    else $error("sense alarm ripe without condition");
  a_dual_compare: assert property (!windowMode |=>
    highCompareOut == !$past(sense.measAboveHigh)
    && lowCompareOut == $past(sense.measAboveLow))
    else $error("dual compare outputs wrong");
  a_window_compare: assert property (windowMode |=>
    highCompareOut == ($past(sense.measAboveLow) && !$past(sense.measAboveHigh)))
    else $error("window compare output wrong");
  a_clamp_latch_hold: assert property (clampLatch && status[dps_pkg::ST_CLAMP]
    && !(regWrite && regAddr == dps_pkg::ADDR_STATUS) |=> !clampAlarmNOeN)
    else $error("latched clamp alarm released");
  a_clamp_enable: assert property (loadSel != dps_pkg::LOAD_CLAMP
    |=> clampActive == $past(clampEnablePin))
    else $error("clamp enable pin not followed");
  a_gpo_diode: assert property (diag[3:0] != 4'h0 |=> generalOutputOeN)
    else $error("general output driven while diode selected");
  a_sys_ground: assert property (systemGroundSwitch |-> guardTristate)
    else $error("system ground closed with guard active");
endmodule : dps_flag_logic

`default_nettype wire

//--- tb/dps_ctrl_model.sv
// Tester controller side of the open-drain alarm flags
`timescale 1ns/1ns
`default_nettype none

module dps_ctrl_model (
  input  wire logic kelvinAlarmNOut, // Kelvin flag drive value
  input  wire logic kelvinAlarmNOeN, // Kelvin flag drive, low
  input  wire logic clampAlarmNOut,  // Clamp flag drive value
  input  wire logic clampAlarmNOeN,  // Clamp flag drive, low
  output logic      kelvinAlarmNIn,  // Kelvin wire seen by controller
  output logic      clampAlarmNIn    // Clamp wire seen by controller
);
  // Board pull-ups hold a released open-drain flag high
  assign kelvinAlarmNIn = kelvinAlarmNOeN ? 1'b1 : kelvinAlarmNOut;
  assign clampAlarmNIn  = clampAlarmNOeN ? 1'b1 : clampAlarmNOut;
endmodule : dps_ctrl_model

`default_nettype wire

//--- tb/tb_dps_flag_logic.sv
// Self-checking bench of the flag logic
`timescale 1ns/1ns
`default_nettype none

module tb_dps_flag_logic;
  localparam int KD = 4;
  localparam int GD = 8;
  logic mclk = 0, reset = 1, regWrite = 0, regRead = 0;
  logic [3:0] regAddr = '0, diodeSelect;
  logic [15:0] regWrData = '0, regRdData, rd, v, loExp;
  dps_pkg::dps_sense_s sense = '0;
  dps_pkg::dps_levels_s levels;
  logic clampEnablePin = 1, hardwareInhibitN = 1, kelvinAlarmNIn, clampAlarmNIn;
  logic kelvinAlarmNOut, kelvinAlarmNOeN, clampAlarmNOut, clampAlarmNOeN;
  logic generalOutputPin, generalOutputOeN, highCompareOut, lowCompareOut;
  logic groundPullupEnable, forceHighZ, clampActive, guardTristate, systemGroundSwitch;
  int num_errors = 0, cmp_count = 0, cycles = 0, n;

  dps_flag_logic #(.KELVIN_DELAY(16'h0004), .GUARD_DELAY(16'h0008)) i_dut (.mclk, .reset,
    .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .sense, .clampEnablePin,
    .hardwareInhibitN, .kelvinAlarmNIn, .kelvinAlarmNOut, .kelvinAlarmNOeN, .clampAlarmNIn,
    .clampAlarmNOut, .clampAlarmNOeN, .generalOutputPin, .generalOutputOeN, .diodeSelect,
    .highCompareOut, .lowCompareOut, .levels, .groundPullupEnable, .forceHighZ,
    .clampActive, .guardTristate, .systemGroundSwitch);
  dps_ctrl_model i_ctrl (.kelvinAlarmNOut, .kelvinAlarmNOeN, .clampAlarmNOut,
    .clampAlarmNOeN, .kelvinAlarmNIn, .clampAlarmNIn);

  always #5 mclk = ~mclk;

  task automatic complete_run();
    if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // Hang guard well beyond the planned sequence
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      $display("[FAIL] %0t run did not finish", $time);
      complete_run();
    end
  end

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    regWrite <= 1'b1; regAddr <= a; regWrData <= d;
    @(posedge mclk);
    regWrite <= 1'b0;
    #1;
  endtask : wr

  task automatic rdw(input logic [3:0] a);
    @(posedge mclk);
    regRead <= 1'b1; regAddr <= a;
    @(posedge mclk);
    regRead <= 1'b0;
    #1 rd = regRdData;
  endtask : rdw

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : cyc

  // Edges from cause to a low Kelvin wire, bounded
  task automatic waitKel();
    n = 0;
    #1;
    while (kelvinAlarmNIn !== 1'b0 && n < 100) begin
      cyc(1);
      n++;
    end
  endtask : waitKel

  initial begin
    void'($urandom(32'h655b));
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    cyc(1);
    chk(levels.groundSenseThresholdDac, dps_pkg::GND_THR_RESET);
    chk(forceHighZ, 1'b0);
    // ------------------------------------------------------------
    // Clamp code saturation, boundaries first
    // ------------------------------------------------------------
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 16'h8000 : (i == 1) ? 16'h7fff : 16'($urandom);
      loExp = (v > 16'h7fff) ? 16'h7fff : v;
      wr(dps_pkg::ADDR_CLAMP_LO, v);
      wr(dps_pkg::ADDR_CLAMP_HI, ~v);
      cyc(1);
      chk(levels.lowCurrentLimit, loExp);
      chk(levels.highCurrentLimit, (~v < 16'h8000) ? 16'h8000 : ~v);
      rdw(dps_pkg::ADDR_CLAMP_LO);
      chk(rd, loExp);
    end
    wr(4'hf, 16'hffff);
    rdw(4'hf);
    chk(rd, 16'h0000);
    // Legal clamp pair, then comparator and ground levels
    loExp = 16'h2000;
    wr(dps_pkg::ADDR_CLAMP_LO, loExp);
    wr(dps_pkg::ADDR_CLAMP_HI, 16'he000);
    v = 16'($urandom);
    wr(dps_pkg::ADDR_CMP_LO, v);
    wr(dps_pkg::ADDR_CMP_HI, ~v);
    wr(dps_pkg::ADDR_GND_THR, v ^ 16'h00ff);
    cyc(1);
    chk(levels.lowCurrentLimit, loExp);
    chk(levels.highCurrentLimit, 16'he000);
    chk(levels.lowCompareLevel, v);
    chk(levels.highCompareLevel, ~v);
    chk(levels.groundSenseThresholdDac, v ^ 16'h00ff);
    rdw(dps_pkg::ADDR_CMP_HI);
    chk(rd, ~v);
    // ------------------------------------------------------------
    // Comparators, dual then window
    // ------------------------------------------------------------
    for (int m = 0; m < 2; m++) begin
      wr(dps_pkg::ADDR_DPS2, 16'(m));
      for (int i = 0; i < 4; i++) begin
        @(posedge mclk);
        sense.measAboveHigh <= i[1];
        sense.measAboveLow <= i[0];
        cyc(1);
        chk(highCompareOut, m ? (i[0] & !i[1]) : !i[1]);
        chk(lowCompareOut, i[0]);
      end
    end
    // Pin outputs follow a register write by one more edge
    wr(dps_pkg::ADDR_DPS2, 16'h0002);
    cyc(1);
    chk({generalOutputOeN, generalOutputPin}, 2'b01);
    wr(dps_pkg::ADDR_DIAG, 16'h0005);
    cyc(1);
    chk({generalOutputOeN, diodeSelect}, 5'h15);
    wr(dps_pkg::ADDR_DIAG, 16'h0000);
    wr(dps_pkg::ADDR_DPS2, 16'h0008);
    cyc(1);
    chk(systemGroundSwitch, 1'b0);
    wr(dps_pkg::ADDR_DPS2, 16'h000c);
    cyc(1);
    chk({guardTristate, systemGroundSwitch}, 2'b11);
    // Inhibit pin, inhibit bit and clamp enable pin
    @(posedge mclk);
    hardwareInhibitN <= 1'b0;
    clampEnablePin <= 1'b0;
    cyc(1);
    chk({forceHighZ, clampActive}, 2'b10);
    @(posedge mclk);
    hardwareInhibitN <= 1'b1;
    clampEnablePin <= 1'b1;
    cyc(1);
    chk({forceHighZ, clampActive}, 2'b01);
    wr(dps_pkg::ADDR_DPS1, 16'h0001);
    cyc(1);
    chk(forceHighZ, 1'b1);
    wr(dps_pkg::ADDR_DPS1, 16'h0000);
    // ------------------------------------------------------------
    // Load strobe on each selectable pin
    // ------------------------------------------------------------
    for (int s = 1; s < 3; s++) begin
      wr(dps_pkg::ADDR_DPS2, 16'(s << 4));
      v = 16'($urandom) & 16'h7fff;
      wr(dps_pkg::ADDR_CLAMP_LO, v);
      cyc(3);
      chk(levels.lowCurrentLimit, loExp);
      @(posedge mclk);
      if (s == 1) clampEnablePin <= 1'b0;
      else hardwareInhibitN <= 1'b0;
      @(posedge mclk);
      clampEnablePin <= 1'b1;
      hardwareInhibitN <= 1'b1;
      cyc(2);
      loExp = v;
      chk({levels.lowCurrentLimit, forceHighZ}, {v, 1'b0});
    end
    wr(dps_pkg::ADDR_DPS2, 16'h0000);
    // ------------------------------------------------------------
    // Kelvin flag: open sense, ground fault, guard short
    // ------------------------------------------------------------
    for (int k = 0; k < 6; k++) begin
      wr(dps_pkg::ADDR_ALARM, (k < 3) ? 16'h0000 : (k == 3) ? 16'h2000 :
         (k == 4) ? 16'h0800 : 16'h0080);
      @(posedge mclk);
      sense.senseOpen <= (k % 3 == 0);
      sense.groundFault <= (k % 3 == 1);
      sense.guardShort <= (k % 3 == 2);
      waitKel();
      chk(16'(n), 16'(((k % 3 == 2) ? GD : KD) + ((k < 3) ? 1 : 2)));
      rdw(dps_pkg::ADDR_STATUS);
      chk(rd & 16'h0017, 16'h0010 | 16'(1 << (k % 3)));
      @(posedge mclk);
      sense <= '0;
      cyc(5);
      chk(kelvinAlarmNIn, k > 2 ? 1'b0 : 1'b1);
      wr(dps_pkg::ADDR_STATUS, 16'h000f);
      cyc(2);
      chk(kelvinAlarmNIn, 1'b1);
    end
    // Ground alarm disabled
    wr(dps_pkg::ADDR_ALARM, 16'h0400);
    @(posedge mclk);
    sense.groundFault <= 1'b1;
    cyc(KD + 4);
    chk({groundPullupEnable, kelvinAlarmNIn}, 2'b01);
    rdw(dps_pkg::ADDR_STATUS);
    chk(rd & 16'h0002, 16'h0000);
    @(posedge mclk);
    sense.groundFault <= 1'b0;
    // ------------------------------------------------------------
    // Clamp flag, unlatched then latched
    // ------------------------------------------------------------
    for (int l = 0; l < 2; l++) begin
      wr(dps_pkg::ADDR_DPS2, l ? 16'h0040 : 16'h0000);
      @(posedge mclk);
      sense.clampHit <= 1'b1;
      cyc(2);
      chk(clampAlarmNIn, 1'b0);
      rdw(dps_pkg::ADDR_STATUS);
      chk(rd & 16'h0028, 16'h0028);
      @(posedge mclk);
      sense.clampHit <= 1'b0;
      cyc(3);
      chk(clampAlarmNIn, l ? 1'b0 : 1'b1);
      wr(dps_pkg::ADDR_STATUS, 16'h0008);
      cyc(2);
      chk(clampAlarmNIn, 1'b1);
    end
    complete_run();
  end
endmodule : tb_dps_flag_logic

`default_nettype wire
